/* rtl/dcl_dac_control.sv */
// How it works
// - enabling the converter starts converting the sample already held
// - sample registers take writes while disabled; that value converts first
// - alignment_select 0 means left-aligned sample, 1 means right-aligned
// - left-aligned, writing only the high byte gives an 8-bit sample
// - power field goes to the converter; 00 fastest, 10 slowest settling
// - reference code: 000 supply, 011 external pin, 1xx buffered internal levels
// - reference buffer on only if 1xx, enabled, and output routed to pin
// - if ADC and converter both want the reference pin, converter wins
// - sample_format_select 0 unsigned, 1 two's complement
// - trigger source 0: writing the high byte starts a conversion
// - trigger source 1: an event pulse, not a high-byte write, starts a conversion
// - event mode: DMA request asserted while converting; request status flag set on each start
`timescale 1ns/1ns
`default_nettype none
module dcl_dac_control
    import dcl_pkg::*;
#(
    parameter int DAC_W = 12
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic event_in,
    input wire logic dac_pin_routed,
    input wire logic adc_vref_request,
    output logic [DAC_W-1:0] dac_code,
    output logic [1:0] dac_power,
    output logic conv_start,
    output logic conv_busy,
    output logic ref_sel_supply,
    output logic ref_sel_ext_pin,
    output logic [1:0] ref_buf_level,
    output logic ref_buf_enable,
    output logic adc_vref_grant,
    output logic dma_req,
    output logic irq
);
    dcl_reg_if rif();

    dcl_axil_slave u_slave (
        .aclk(aclk),
        .aresetn(aresetn),
        .awaddr(s_axi_awaddr),
        .awvalid(s_axi_awvalid),
        .awready(s_axi_awready),
        .wdata(s_axi_wdata),
        .wstrb(s_axi_wstrb),
        .wvalid(s_axi_wvalid),
        .wready(s_axi_wready),
        .bresp(s_axi_bresp),
        .bvalid(s_axi_bvalid),
        .bready(s_axi_bready),
        .araddr(s_axi_araddr),
        .arvalid(s_axi_arvalid),
        .arready(s_axi_arready),
        .rdata(s_axi_rdata),
        .rresp(s_axi_rresp),
        .rvalid(s_axi_rvalid),
        .rready(s_axi_rready),
        .rif(rif.bus_end)
    );

    // offset binary out to the analog side; signed input flips the msb
    function automatic logic [DAC_W-1:0] compose(input logic [7:0] lo, input logic [7:0] hi,
                                                 input logic right, input logic signd);
        logic [DAC_W-1:0] raw;
        raw = right ? {hi[DAC_W-9:0], lo} : {hi, lo[7:16-DAC_W]};
        compose = signd ? (raw ^ {1'b1, {(DAC_W-1){1'b0}}}) : raw;
    endfunction

    function automatic logic [CNT_W-1:0] settle(input logic [1:0] pwr);
        if (pwr == PWR_FAST)
            settle = SETTLE_FAST_CYC;
        else if (pwr == PWR_SLOW)
            settle = SETTLE_SLOW_CYC;
        else
            settle = SETTLE_MID_CYC;
    endfunction

    logic [7:0] ctrl, lo, hi;
    logic enable, en_q;
    logic [1:0] status, mask;
    logic [CNT_W-1:0] cnt;
    logic [7:0] next_ctrl, next_lo, next_hi;
    logic next_enable, next_busy, next_start;
    logic [1:0] next_status, next_mask;
    logic [CNT_W-1:0] next_cnt;
    logic [DAC_W-1:0] next_code, held_code;
    logic wr_lane0, wr_hi, trig_evt, start, done;
    logic [2:0] positive_reference_select;

    assign positive_reference_select = ctrl[CTRL_REF_LSB +: 3];
    assign trig_evt = ctrl[CTRL_TRIG_BIT];
    assign wr_lane0 = rif.wr_en && rif.wr_strb[0];
    assign wr_hi = wr_lane0 && rif.wr_addr == OFF_HI;
    assign rif.wr_ok = rif.wr_addr inside {OFF_CTRL, OFF_CFG, OFF_LO, OFF_HI, OFF_STAT,
                                           OFF_MASK, OFF_STATE};
    assign rif.rd_ok = rif.rd_addr inside {OFF_CTRL, OFF_CFG, OFF_LO, OFF_HI, OFF_STAT,
                                           OFF_MASK, OFF_STATE};

    // registers and conversion start
    always_comb begin
        next_ctrl = ctrl;
        next_enable = enable;
        next_lo = lo;
        next_hi = hi;
        next_mask = mask;
        if (wr_lane0 && rif.wr_addr == OFF_CTRL)
            next_ctrl = rif.wr_data[7:0];
        if (wr_lane0 && rif.wr_addr == OFF_CFG)
            next_enable = rif.wr_data[CFG_EN_BIT];
        // data writes land whether or not the converter is enabled
        if (wr_lane0 && rif.wr_addr == OFF_LO)
            next_lo = rif.wr_data[7:0];
        if (wr_hi)
            next_hi = rif.wr_data[7:0];
        if (wr_lane0 && rif.wr_addr == OFF_MASK)
            next_mask = rif.wr_data[1:0];
        // same-cycle write is seen, so a high-byte write converts its own value
        held_code = compose(next_lo, next_hi, ctrl[CTRL_ALIGN_BIT], ctrl[CTRL_FMT_BIT]);
        start = (enable && !en_q)
              || (enable && !trig_evt && wr_hi)
              || (enable && trig_evt && event_in);
        next_code = start ? held_code : dac_code;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl <= CTRL_RST;
            enable <= 1'b0;
            en_q <= 1'b0;
            lo <= DATA_RST;
            hi <= DATA_RST;
            mask <= IRQ_RST;
            dac_code <= '0;
            conv_start <= 1'b0;
        end else begin
            ctrl <= next_ctrl;
            enable <= next_enable;
            en_q <= enable;
            lo <= next_lo;
            hi <= next_hi;
            mask <= next_mask;
            dac_code <= next_code;
            conv_start <= start;
        end
    end

    // settling counter; a new start restarts it, disabling aborts it
    always_comb begin
        done = conv_busy && cnt == CNT_W'(1);
        next_cnt = cnt;
        next_busy = conv_busy;
        if (!enable) begin
            next_busy = 1'b0;
            next_cnt = '0;
        end else if (start) begin
            next_busy = 1'b1;
            next_cnt = settle(dac_power);
        end else if (conv_busy) begin
            next_cnt = cnt - CNT_W'(1);
            next_busy = !done;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            conv_busy <= 1'b0;
            cnt <= '0;
        end else begin
            conv_busy <= next_busy;
            cnt <= next_cnt;
        end
    end

    // sticky status, write one to clear; a set in the clearing cycle wins
    always_comb begin
        next_status = status;
        if (wr_lane0 && rif.wr_addr == OFF_STAT)
            next_status = status & ~rif.wr_data[1:0];
        if (start && trig_evt)
            next_status[ST_REQ_BIT] = 1'b1;
        if (done)
            next_status[ST_DONE_BIT] = 1'b1;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn)
            status <= IRQ_RST;
        else
            status <= next_status;
    end

    assign irq = |(status & mask);
    assign dma_req = conv_busy && trig_evt;
    assign dac_power = ctrl[CTRL_PWR_LSB +: 2];
    // reserved codes 001 and 010 select nothing
    assign ref_sel_supply = positive_reference_select == REF_SUPPLY;
    assign ref_sel_ext_pin = positive_reference_select == REF_EXT_PIN;
    assign ref_buf_level = positive_reference_select[2] ? positive_reference_select[1:0] : 2'h0;
    assign ref_buf_enable = positive_reference_select[2] && enable && dac_pin_routed;
    // the converter's buffer selection owns the pin even while it is off
    assign adc_vref_grant = adc_vref_request && !positive_reference_select[2];

    always_comb begin
        rif.rd_data = 32'h0;
        unique case (rif.rd_addr)
            OFF_CTRL: rif.rd_data[7:0] = ctrl;
            OFF_CFG: rif.rd_data[CFG_EN_BIT] = enable;
            OFF_LO: rif.rd_data[7:0] = lo;
            OFF_HI: rif.rd_data[7:0] = hi;
            OFF_STAT: rif.rd_data[1:0] = status;
            OFF_MASK: rif.rd_data[1:0] = mask;
            OFF_STATE: rif.rd_data = {15'h0, conv_busy, 4'h0, dac_code};
            default: rif.rd_data = 32'h0;
        endcase
    end

    a_enable_starts: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(enable) |=> conv_start && conv_busy)
        else $error("enable did not start a conversion");
    a_held_word: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(enable) |=> dac_code == $past(held_code))
        else $error("held word not converted on enable");
    a_right_align: assert property (@(posedge aclk) disable iff (!aresetn)
        conv_start && $past(ctrl[CTRL_ALIGN_BIT] && !ctrl[CTRL_FMT_BIT])
        |-> dac_code == {hi[3:0], lo})
        else $error("right-aligned sample wrong");
    a_left_byte: assert property (@(posedge aclk) disable iff (!aresetn)
        conv_start && $past(!ctrl[CTRL_ALIGN_BIT] && !ctrl[CTRL_FMT_BIT])
        |-> dac_code[11:4] == hi)
        else $error("left-aligned high byte wrong");
    a_power_settle: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(conv_busy) && dac_power == PWR_FAST && enable && !start
        |-> cnt == SETTLE_FAST_CYC)
        else $error("fast settle count wrong");
    a_ref_decode: assert property (@(posedge aclk) disable iff (!aresetn)
        ref_sel_ext_pin |-> !ref_sel_supply && !ref_buf_enable && positive_reference_select == 3'h3)
        else $error("reference decode wrong");
    a_buf_auto: assert property (@(posedge aclk) disable iff (!aresetn)
        ref_buf_enable == (positive_reference_select[2] && enable && dac_pin_routed))
        else $error("reference buffer enable wrong");
    a_vref_exclusive: assert property (@(posedge aclk) disable iff (!aresetn)
        !(adc_vref_grant && positive_reference_select[2]))
        else $error("both buffers on reference pin");
    a_signed_msb: assert property (@(posedge aclk) disable iff (!aresetn)
        conv_start && $past(ctrl[CTRL_ALIGN_BIT] && ctrl[CTRL_FMT_BIT])
        |-> dac_code[11] == !hi[3])
        else $error("signed sample not offset");
    a_write_trig: assert property (@(posedge aclk) disable iff (!aresetn)
        enable && en_q && !trig_evt && wr_hi |=> conv_start ##1 conv_busy)
        else $error("high byte write did not start");
    a_event_only: assert property (@(posedge aclk) disable iff (!aresetn)
        enable && en_q && trig_evt && !event_in |=> !conv_start)
        else $error("start without event");
    a_event_reqs: assert property (@(posedge aclk) disable iff (!aresetn)
        conv_start && $past(trig_evt) && enable |-> dma_req && status[ST_REQ_BIT])
        else $error("event-mode requests missing");
    // outputs held against the register fields, and status against internal terms such as done and start
    a_no_start_off: assert property (@(posedge aclk) disable iff (!aresetn)
        !enable |=> !conv_start)
        else $error("conversion started while disabled");
    a_disable_stops: assert property (@(posedge aclk) disable iff (!aresetn)
        !enable |=> !conv_busy)
        else $error("busy kept after disable");
    a_status_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
        status[ST_REQ_BIT] && !(wr_lane0 && rif.wr_addr == OFF_STAT) |=> status[ST_REQ_BIT])
        else $error("request flag lost without clear");
    a_done_flag: assert property (@(posedge aclk) disable iff (!aresetn)
        done && !start |=> status[ST_DONE_BIT] && !conv_busy)
        else $error("settling end not flagged");
    a_slow_settle: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(conv_busy) && $past(dac_power) == PWR_SLOW |-> cnt == SETTLE_SLOW_CYC)
        else $error("slow settle count wrong");
    a_dma_mode: assert property (@(posedge aclk) disable iff (!aresetn)
        !trig_evt |-> !dma_req)
        else $error("dma request in write-trigger mode");
    a_ref_level: assert property (@(posedge aclk) disable iff (!aresetn)
        !positive_reference_select[2] |-> ref_buf_level == 2'h0 && !ref_buf_enable)
        else $error("buffer level without buffered code");
    a_reserved_ref: assert property (@(posedge aclk) disable iff (!aresetn)
        positive_reference_select inside {3'h1, 3'h2} |-> !ref_sel_supply && !ref_sel_ext_pin && !ref_buf_enable)
        else $error("reserved reference code selected something");
    a_vref_pass: assert property (@(posedge aclk) disable iff (!aresetn)
        adc_vref_request && !positive_reference_select[2] |-> adc_vref_grant)
        else $error("adc refused a free reference pin");
    a_buf_off: assert property (@(posedge aclk) disable iff (!aresetn)
        (!enable || !dac_pin_routed) |-> !ref_buf_enable)
        else $error("reference buffer on while not needed");
endmodule
`default_nettype wire

/* rtl/dcl_pkg.sv */
package dcl_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_CFG = 8'h04;
    localparam logic [7:0] OFF_LO = 8'h08;
    localparam logic [7:0] OFF_HI = 8'h0c;
    localparam logic [7:0] OFF_STAT = 8'h10;
    localparam logic [7:0] OFF_MASK = 8'h14;
    localparam logic [7:0] OFF_STATE = 8'h18;
    // converter_control, config, status and state fields
    localparam int CTRL_ALIGN_BIT = 0;
    localparam int CTRL_TRIG_BIT = 1;
    localparam int CTRL_FMT_BIT = 2;
    localparam int CTRL_REF_LSB = 3;
    localparam int CTRL_PWR_LSB = 6;
    localparam int CFG_EN_BIT = 0;
    localparam int ST_REQ_BIT = 0;
    localparam int ST_DONE_BIT = 1;
    localparam int STATE_BUSY_BIT = 16;
    // reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [1:0] IRQ_RST = 2'h0;
    // codes
    localparam logic [1:0] PWR_FAST = 2'h0;
    localparam logic [1:0] PWR_SLOW = 2'h2;
    localparam logic [2:0] REF_SUPPLY = 3'h0;
    localparam logic [2:0] REF_EXT_PIN = 3'h3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // settling times
    localparam int CLK_NS = 50;
    localparam int SETTLE_FAST_NS = 2000;
    localparam int SETTLE_MID_NS = 5000;
    localparam int SETTLE_SLOW_NS = 10000;
    localparam int CNT_W = 9;
    localparam logic [CNT_W-1:0] SETTLE_FAST_CYC = CNT_W'((SETTLE_FAST_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [CNT_W-1:0] SETTLE_MID_CYC = CNT_W'((SETTLE_MID_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [CNT_W-1:0] SETTLE_SLOW_CYC = CNT_W'((SETTLE_SLOW_NS + CLK_NS - 1) / CLK_NS);
endpackage

/* rtl/dcl_reg_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface dcl_reg_if;
    logic wr_en;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_ok;
    logic rd_en;
    logic [7:0] rd_addr;
    logic [31:0] rd_data;
    logic rd_ok;
    modport bus_end(output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
                    input wr_ok, rd_data, rd_ok);
    modport reg_end(input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
                    output wr_ok, rd_data, rd_ok);
endinterface
`default_nettype wire

/* rtl/dcl_axil_slave.sv */
`timescale 1ns/1ns
`default_nettype none
module dcl_axil_slave
    import dcl_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    dcl_reg_if.bus_end rif
);
    logic aw_held, w_held;
    logic [7:0] aw_q;
    logic [31:0] w_q;
    logic [3:0] s_q;
    logic next_aw_held, next_w_held, next_bvalid, next_rvalid;
    logic [7:0] next_aw_q;
    logic [31:0] next_w_q, next_rdata;
    logic [3:0] next_s_q;
    logic [1:0] next_bresp, next_rresp;

    // address and data are caught separately, in either order
    assign awready = !aw_held && !bvalid;
    assign wready = !w_held && !bvalid;
    assign arready = !rvalid;
    assign rif.wr_en = aw_held && w_held && !bvalid;
    assign rif.wr_addr = aw_q;
    assign rif.wr_data = w_q;
    assign rif.wr_strb = s_q;
    assign rif.rd_en = arvalid && arready;
    assign rif.rd_addr = araddr;

    always_comb begin
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_aw_q = aw_q;
        next_w_q = w_q;
        next_s_q = s_q;
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        if (awvalid && awready) begin
            next_aw_held = 1'b1;
            next_aw_q = awaddr;
        end
        if (wvalid && wready) begin
            next_w_held = 1'b1;
            next_w_q = wdata;
            next_s_q = wstrb;
        end
        if (rif.wr_en) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = rif.wr_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (bvalid && bready) begin
            next_bvalid = 1'b0;
        end
        if (rif.rd_en) begin
            next_rvalid = 1'b1;
            next_rdata = rif.rd_ok ? rif.rd_data : 32'h0;
            next_rresp = rif.rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid && rready) begin
            next_rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_q <= 8'h0;
            w_q <= 32'h0;
            s_q <= 4'h0;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
            rvalid <= 1'b0;
            rdata <= 32'h0;
            rresp <= RESP_OKAY;
        end else begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_q <= next_aw_q;
            w_q <= next_w_q;
            s_q <= next_s_q;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
        end
    end
endmodule
`default_nettype wire

/* dv/dcl_evt_src.sv */
`timescale 1ns/1ns
`default_nettype none
module dcl_evt_src (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic fire,
    input wire logic [3:0] lag,
    output logic event_pulse
);
    logic [4:0] cnt;
    logic [4:0] next_cnt;
    logic next_event_pulse;
    // one pulse per request, lag+1 cycles after fire is taken, so slow routing is covered too
    always_comb begin
        next_cnt = cnt;
        next_event_pulse = 1'h0;
        if (fire) begin
            next_cnt = {1'h0, lag} + 5'h1;
        end else if (cnt != 5'h0) begin
            next_cnt = cnt - 5'h1;
            next_event_pulse = (cnt == 5'h1);
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt <= 5'h0;
            event_pulse <= 1'h0;
        end else begin
            cnt <= next_cnt;
            event_pulse <= next_event_pulse;
        end
    end
endmodule
`default_nettype wire

/* dv/dac_control_logic_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module dac_control_logic_tb;
    import dcl_pkg::*;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, fire, pin_routed, adc_req;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb, lag;
    logic awready, wready, bvalid, arready, rvalid, evt, conv_start, conv_busy, dma_req, irq;
    logic ref_sup, ref_ext, ref_en, grant;
    logic [1:0] bresp, rresp, dac_power, ref_lvl, resp;
    logic [11:0] dac_code, last_code;
    int error_cnt = 0, checks = 0, starts = 0, busy_cyc = 0, dma_cyc = 0, s0;

    initial aclk = 1'h0;
    always #25 aclk = ~aclk;

    dcl_dac_control dcl_dac_control_inst (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .event_in(evt), .dac_pin_routed(pin_routed), .adc_vref_request(adc_req),
        .dac_code(dac_code), .dac_power(dac_power), .conv_start(conv_start),
        .conv_busy(conv_busy), .ref_sel_supply(ref_sup), .ref_sel_ext_pin(ref_ext),
        .ref_buf_level(ref_lvl), .ref_buf_enable(ref_en), .adc_vref_grant(grant),
        .dma_req(dma_req), .irq(irq));

    dcl_evt_src dcl_evt_src_inst (.aclk(aclk), .aresetn(aresetn), .fire(fire), .lag(lag),
        .event_pulse(evt));

    // sampled values at the edge are the settled ones of the cycle before
    always @(posedge aclk) begin
        if (conv_start === 1'h1) begin
            starts <= starts + 1;
            last_code <= dac_code;
        end
        if (conv_busy === 1'h1) busy_cyc <= busy_cyc + 1;
        if (dma_req === 1'h1) dma_cyc <= dma_cyc + 1;
    end

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'h1);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'h0;
            if (wvalid && wready) wvalid <= 1'h0;
        end while (bvalid !== 1'h1);
        resp = bresp;
        bready <= 1'h0;
    endtask

    task axr(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'h0;
        end while (rvalid !== 1'h1);
        rd = rdata;
        resp = rresp;
        rready <= 1'h0;
    endtask

    task idle(input int n);
        repeat (n) @(posedge aclk);
    endtask

    task wait_idle;
        int n;
        n = 0;
        idle(2);
        while (conv_busy !== 1'h0 && n < 400) begin
            @(posedge aclk);
            n++;
        end
    endtask

    task pulse_evt(input logic [3:0] l);
        @(posedge aclk);
        lag <= l;
        fire <= 1'h1;
        @(posedge aclk);
        fire <= 1'h0;
    endtask

    function logic [11:0] smp(input logic right, input logic sgn, input logic [7:0] hi,
                              input logic [7:0] lo);
        logic [11:0] v;
        v = right ? {hi[3:0], lo} : {hi, lo[7:4]};
        return sgn ? (v ^ 12'h800) : v;
    endfunction

    task results;
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // whole sequence is well under a thousand cycles
    initial begin
        repeat (20000) @(posedge aclk);
        error_cnt++;
        results;
    end

    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, fire, pin_routed, adc_req} = '0;
        {awaddr, araddr, wdata, wstrb, lag} = '0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'h1;
        axr(OFF_CTRL);
        chk(rd, {24'h0, CTRL_RST});
        axr(OFF_STATE);
        chk(rd, 32'h0);
        axr(8'h1c);
        chk(32'(resp), 32'(RESP_SLVERR));
        axw(8'h1c, 32'hff);
        chk(32'(resp), 32'(RESP_SLVERR));
        chk(32'(irq), 32'h0);
        $display("test reset done");
        axw(OFF_LO, 32'h5a);
        axw(OFF_HI, 32'ha3);
        idle(4);
        chk(32'(starts), 32'h0);
        axw(OFF_CFG, 32'h1);
        idle(4);
        chk(32'(starts), 32'h1);
        chk(32'(last_code), 32'(smp(0, 0, 8'ha3, 8'h5a)));
        axr(OFF_STATE);
        chk({rd[16], rd[11:0]}, {1'h1, smp(0, 0, 8'ha3, 8'h5a)});
        $display("test preload done");
        axw(OFF_HI, 32'h7c);
        idle(4);
        chk(32'(starts), 32'h2);
        chk(32'(last_code), 32'(smp(0, 0, 8'h7c, 8'h5a)));
        pulse_evt(4'h0);
        idle(4);
        chk(32'(starts), 32'h2);
        axw(OFF_CTRL, 32'h1, 4'he);
        axr(OFF_CTRL);
        chk(rd, 32'h0);
        axw(OFF_CTRL, 32'h1);
        axw(OFF_LO, 32'h34);
        idle(3);
        chk(32'(starts), 32'h2);
        axw(OFF_HI, 32'h0b);
        idle(3);
        chk(32'(last_code), 32'(smp(1, 0, 8'h0b, 8'h34)));
        axw(OFF_CTRL, 32'h5);
        axw(OFF_LO, 32'hff);
        axw(OFF_HI, 32'h07);
        idle(3);
        chk(32'(last_code), 32'(smp(1, 1, 8'h07, 8'hff)));
        chk(32'(starts), 32'h4);
        $display("test write trigger done");
        for (int i = 0; i < 2; i++) begin
            wait_idle;
            axw(OFF_STAT, 32'h3);
            axw(OFF_CTRL, {24'h0, i ? PWR_SLOW : PWR_FAST, 6'h0});
            chk(32'(dac_power), 32'(i ? PWR_SLOW : PWR_FAST));
            busy_cyc = 0;
            dma_cyc = 0;
            axw(OFF_HI, 32'h80);
            wait_idle;
            chk(32'(busy_cyc), 32'(i ? SETTLE_SLOW_CYC : SETTLE_FAST_CYC));
            chk(32'(dma_cyc), 32'h0);
            axr(OFF_STAT);
            chk(rd, 32'h2);
            chk(32'(irq), 32'h0);
        end
        axw(OFF_MASK, 32'h2);
        idle(1);
        chk(32'(irq), 32'h1);
        axw(OFF_STAT, 32'h2);
        idle(1);
        chk(32'(irq), 32'h0);
        $display("test power done");
        pin_routed <= 1'h1;
        adc_req <= 1'h1;
        for (int c = 0; c < 8; c++) begin
            axw(OFF_CTRL, 32'(c << 3));
            idle(1);
            chk({27'h0, ref_sup, ref_ext, ref_lvl, ref_en},
                {27'h0, c == 0, c == 3, c[2] ? c[1:0] : 2'h0, c[2]});
            chk(32'(grant), 32'(c < 4));
        end
        pin_routed <= 1'h0;
        idle(2);
        chk(32'(ref_en), 32'h0);
        pin_routed <= 1'h1;
        axw(OFF_CFG, 32'h0);
        idle(1);
        chk({30'h0, ref_en, grant}, 32'h0);
        axw(OFF_CFG, 32'h1);
        $display("test reference done");
        axw(OFF_CTRL, 32'h2);
        axw(OFF_MASK, 32'h1);
        wait_idle;
        s0 = starts;
        axw(OFF_HI, 32'h55);
        idle(3);
        chk(32'(starts), 32'(s0));
        for (int k = 0; k < 2; k++) begin
            busy_cyc = 0;
            dma_cyc = 0;
            pulse_evt(k ? 4'h6 : 4'h0);
            idle(k ? 10 : 4);
            chk(32'(starts), 32'(s0 + k + 1));
            chk({30'h0, dma_req, irq}, 32'h3);
            chk(32'(last_code), 32'(smp(0, 0, 8'h55, 8'hff)));
            wait_idle;
            chk(32'(dma_cyc), 32'(SETTLE_FAST_CYC));
        end
        axw(OFF_MASK, 32'h0);
        idle(1);
        chk(32'(irq), 32'h0);
        axr(OFF_STAT);
        chk(rd, 32'h3);
        axw(OFF_STAT, 32'h3);
        axr(OFF_STAT);
        chk(rd, 32'h0);
        $display("test event trigger done");
        results;
    end
endmodule
`default_nettype wire
